// ---- dcd_pkg.sv ----
`default_nettype none
package dcd_pkg;
    // ************************************************************
    // Opcode word layout
    // ************************************************************
    localparam int OP_HI   = 15;
    localparam int OP_LO   = 10;
    localparam int RSV_BIT = 9;
    localparam int RW_BIT  = 8;
    localparam int SZ_HI   = 7;
    localparam int SZ_LO   = 6;
    localparam int RSV_HI  = 5;
    localparam int RSV_LO  = 4;
    localparam int AD_BIT  = 3;
    localparam int RN_HI   = 2;

    localparam logic [5:0]  OP_NOP   = 6'h00;
    localparam logic [5:0]  OP_MEM   = 6'h06;
    localparam logic [5:0]  OP_REG   = 6'h08;
    localparam logic [15:0] NOP_WORD = 16'h0000;

    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] SZ_RSVD = 2'h3;

    // ************************************************************
    // Responses: status flag in bit 16, data below
    // ************************************************************
    localparam logic [16:0] RSP_OK     = 17'h0ffff;
    localparam logic [16:0] RSP_NOTRDY = 17'h10000;
    localparam logic [16:0] RSP_BERR   = 17'h10001;
    localparam logic [16:0] RSP_ILL    = 17'h1ffff;

    localparam logic [4:0] LAST_BIT  = 5'h10;
    localparam logic [2:0] EXT_ADDR  = 3'h2;
    localparam logic [2:0] EXT_LONG  = 3'h4;
    localparam logic [2:0] EXT_SHORT = 3'h3;

    // ************************************************************
    // Register bus map
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_LAST = 8'h08;
    localparam logic       EN_RST    = 1'b1;
    localparam logic [1:0] RESP_OK   = 2'h0;
    localparam logic [1:0] RESP_ERR  = 2'h2;

    typedef enum logic [4:0] {
        S_IDLE  = 5'h01,
        S_EXT   = 5'h02,
        S_BUSY  = 5'h04,
        S_RESHI = 5'h08,
        S_SPARE = 5'h10
    } dcd_fsm_t;
endpackage
`default_nettype wire

// ---- dcd_debug_command_decoder.sv ----
// Functional notes
// - Command is opcode word plus extension words
// - Decode selector, direction, size, class, number
// - Halted-only commands need stopped core
// - Memory commands steal cycles; NOP parallel
// - Bit 8: zero writes, one reads
// - Size 00 is byte; addresses 32-bit
// - Byte read result in low byte
// - Bit 3 picks data/address register class
// - Address always takes two extension words
// - Force word/long address alignment
// - Immediate words by size, upper first
// - 17-bit exchanges, responses answer earlier transfer
// - Opcode transfer returns previous result/status
// - First extension: not-ready or illegal
// - Low address transfer not-ready, then access
// - Not-ready while access in progress
// - Long and register results in two transfers after completion, word and byte in one
// - Bus error returns flagged 0x0001
// - Flag clear on success, else set
// - Unused formats act as NOP, illegal
// - Register read returns 32 bits, halted only
// - Register write replaces 32 bits, halted only
// - Encodings: ok, not-ready, illegal
// - Register read opcode 0x218 plus fields
// - Register write opcode 0x208, acknowledged ok
`timescale 1ns/1ps
`default_nettype none
module dcd_debug_command_decoder #(
    parameter int AXI_ADDR_W = 8
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_dsclk,
    input  wire logic                  i_dsi,
    output var  logic                  o_dso,
    input  wire logic                  i_core_halted,
    output var  logic                  o_reg_req,
    output var  logic                  o_reg_wr,
    output var  logic                  o_reg_class,
    output var  logic [2:0]            o_reg_num,
    output var  logic [31:0]           o_reg_wdata,
    input  wire logic [31:0]           i_reg_rdata,
    input  wire logic                  i_reg_done,
    output var  logic                  o_mem_req,
    output var  logic                  o_mem_wr,
    output var  logic [1:0]            o_mem_size,
    output var  logic [31:0]           o_mem_addr,
    output var  logic [31:0]           o_mem_wdata,
    input  wire logic [31:0]           i_mem_rdata,
    input  wire logic                  i_mem_done,
    input  wire logic                  i_mem_err,
    input  wire logic [AXI_ADDR_W-1:0] i_s_axi_awaddr,
    input  wire logic                  i_s_axi_awvalid,
    output var  logic                  o_s_axi_awready,
    input  wire logic [31:0]           i_s_axi_wdata,
    input  wire logic [3:0]            i_s_axi_wstrb,
    input  wire logic                  i_s_axi_wvalid,
    output var  logic                  o_s_axi_wready,
    output var  logic [1:0]            o_s_axi_bresp,
    output var  logic                  o_s_axi_bvalid,
    input  wire logic                  i_s_axi_bready,
    input  wire logic [AXI_ADDR_W-1:0] i_s_axi_araddr,
    input  wire logic                  i_s_axi_arvalid,
    output var  logic                  o_s_axi_arready,
    output var  logic [31:0]           o_s_axi_rdata,
    output var  logic [1:0]            o_s_axi_rresp,
    output var  logic                  o_s_axi_rvalid,
    input  wire logic                  i_s_axi_rready
);
    // ************************************************************
    // Elaboration checks
    // ************************************************************
    generate
        if (AXI_ADDR_W < 4 || AXI_ADDR_W > 8) begin : g_bad_addr_w
            $error("AXI_ADDR_W must lie between 4 and 8");
        end
    endgenerate

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        dcd_pkg::dcd_fsm_t fsm;
        logic              clk_s1;
        logic              clk_s2;
        logic              clk_d;
        logic              dat_s1;
        logic              dat_s2;
        logic [4:0]        bit_cnt;
        logic [15:0]       sh_in;
        logic [16:0]       sh_out;
        logic              dso;
        logic [16:0]       tx;
        logic [15:0]       opc;
        logic [2:0]        ext_total;
        logic [2:0]        ext_idx;
        logic [31:0]       addr;
        logic [31:0]       data;
        logic [15:0]       res_lo;
        logic              reg_req;
        logic              mem_req;
        logic [31:0]       mem_addr;
        logic              en;
        logic              last_ill;
        logic [7:0]        aw_addr;
        logic              aw_got;
        logic              w_got;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } dcd_state_t;

    dcd_state_t st_ff;
    dcd_state_t nxt_st;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Only a fixed set of formats is served; every other word is refused
    function automatic logic cmd_legal(input logic [15:0] w);
        logic [5:0] op;
        logic       ok;
        op = w[dcd_pkg::OP_HI:dcd_pkg::OP_LO];
        ok = 1'b0;
        if (w == dcd_pkg::NOP_WORD) begin
            ok = 1'b1;
        end else if (op == dcd_pkg::OP_REG && !w[dcd_pkg::RSV_BIT] &&
                     w[dcd_pkg::RSV_HI:dcd_pkg::RSV_LO] == 2'h0 &&
                     w[dcd_pkg::SZ_HI:dcd_pkg::SZ_LO] == dcd_pkg::SZ_LONG) begin
            ok = 1'b1;
        end else if (op == dcd_pkg::OP_MEM && !w[dcd_pkg::RSV_BIT] &&
                     w[dcd_pkg::RSV_HI:0] == 6'h00 &&
                     w[dcd_pkg::SZ_HI:dcd_pkg::SZ_LO] != dcd_pkg::SZ_RSVD) begin
            ok = 1'b1;
        end
        return ok;
    endfunction

    function automatic logic is_mem(input logic [15:0] w);
        return w[dcd_pkg::OP_HI:dcd_pkg::OP_LO] == dcd_pkg::OP_MEM;
    endfunction

    // Extension word count per legal command
    function automatic logic [2:0] ext_count(input logic [15:0] w);
        logic [2:0] n;
        n = 3'h0;
        if (w[dcd_pkg::OP_HI:dcd_pkg::OP_LO] == dcd_pkg::OP_REG) begin
            n = w[dcd_pkg::RW_BIT] ? 3'h0 : dcd_pkg::EXT_ADDR;
        end else if (is_mem(w)) begin
            if (w[dcd_pkg::RW_BIT]) begin
                n = dcd_pkg::EXT_ADDR;
            end else if (w[dcd_pkg::SZ_HI:dcd_pkg::SZ_LO] == dcd_pkg::SZ_LONG) begin
                n = dcd_pkg::EXT_LONG;
            end else begin
                n = dcd_pkg::EXT_SHORT;
            end
        end
        return n;
    endfunction

    // Low address bits are dropped, not checked
    function automatic logic [31:0] align(input logic [31:0] a, input logic [1:0] sz);
        logic [31:0] r;
        r = a;
        if (sz == dcd_pkg::SZ_WORD) begin
            r = {a[31:1], 1'b0};
        end else if (sz == dcd_pkg::SZ_LONG) begin
            r = {a[31:2], 2'h0};
        end
        return r;
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic        rise;
        logic        done;
        logic [15:0] rx;
        logic        launch;
        logic [1:0]  sz;
        logic        do_aw;
        logic        do_ar;
        nxt_st = st_ff;
        rise   = 1'b0;
        done   = 1'b0;
        rx     = 16'h0000;
        launch = 1'b0;
        sz     = st_ff.opc[dcd_pkg::SZ_HI:dcd_pkg::SZ_LO];
        do_aw  = 1'b0;
        do_ar  = 1'b0;

        // Pin synchronisers; edge found on the second stage only
        nxt_st.clk_s1 = i_dsclk;
        nxt_st.clk_s2 = st_ff.clk_s1;
        nxt_st.clk_d  = st_ff.clk_s2;
        nxt_st.dat_s1 = i_dsi;
        nxt_st.dat_s2 = st_ff.dat_s1;
        rise = st_ff.clk_s2 & ~st_ff.clk_d & st_ff.en;

        // Serial exchange, 17 bits each way, MSB first
        if (rise) begin
            nxt_st.sh_in  = {st_ff.sh_in[14:0], st_ff.dat_s2};
            nxt_st.sh_out = {st_ff.sh_out[15:0], 1'b0};
            if (st_ff.bit_cnt == dcd_pkg::LAST_BIT) begin
                nxt_st.bit_cnt = 5'h00;
                done = 1'b1;
                rx   = {st_ff.sh_in[14:0], st_ff.dat_s2};
            end else begin
                nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
            end
        end else if (st_ff.bit_cnt == 5'h00) begin
            // Reload only between exchanges so a running one is never torn
            nxt_st.sh_out = st_ff.tx;
        end

        // Command sequencing
        unique case (st_ff.fsm)
            dcd_pkg::S_IDLE: begin
                if (done) begin
                    nxt_st.opc      = rx;
                    nxt_st.ext_idx  = 3'h0;
                    nxt_st.last_ill = ~cmd_legal(rx);
                    if (!cmd_legal(rx)) begin
                        nxt_st.tx = dcd_pkg::RSP_ILL;
                    end else if (rx == dcd_pkg::NOP_WORD) begin
                        nxt_st.tx = dcd_pkg::RSP_OK;
                    end else begin
                        nxt_st.tx        = dcd_pkg::RSP_NOTRDY;
                        nxt_st.ext_total = ext_count(rx);
                        if (ext_count(rx) == 3'h0) begin
                            launch = 1'b1;
                        end else begin
                            nxt_st.fsm = dcd_pkg::S_EXT;
                        end
                    end
                end
            end
            dcd_pkg::S_EXT: begin
                if (done) begin
                    nxt_st.tx      = dcd_pkg::RSP_NOTRDY;
                    nxt_st.ext_idx = st_ff.ext_idx + 3'h1;
                    if (is_mem(st_ff.opc) && st_ff.ext_idx < dcd_pkg::EXT_ADDR) begin
                        nxt_st.addr = {st_ff.addr[15:0], rx};
                    end else begin
                        nxt_st.data = {st_ff.data[15:0], rx};
                    end
                    if (st_ff.ext_idx + 3'h1 == st_ff.ext_total) begin
                        launch = 1'b1;
                    end
                end
            end
            dcd_pkg::S_BUSY: begin
                // Exchanges meanwhile keep answering not-ready
                if ((st_ff.reg_req && i_reg_done) || (st_ff.mem_req && i_mem_done)) begin
                    nxt_st.reg_req = 1'b0;
                    nxt_st.mem_req = 1'b0;
                    nxt_st.fsm     = dcd_pkg::S_IDLE;
                    if (st_ff.mem_req && i_mem_err) begin
                        nxt_st.tx = dcd_pkg::RSP_BERR;
                    end else if (!st_ff.opc[dcd_pkg::RW_BIT]) begin
                        nxt_st.tx = dcd_pkg::RSP_OK;
                    end else if (st_ff.reg_req) begin
                        nxt_st.tx     = {1'b0, i_reg_rdata[31:16]};
                        nxt_st.res_lo = i_reg_rdata[15:0];
                        nxt_st.fsm    = dcd_pkg::S_RESHI;
                    end else if (sz == dcd_pkg::SZ_LONG) begin
                        nxt_st.tx     = {1'b0, i_mem_rdata[31:16]};
                        nxt_st.res_lo = i_mem_rdata[15:0];
                        nxt_st.fsm    = dcd_pkg::S_RESHI;
                    end else if (sz == dcd_pkg::SZ_WORD) begin
                        nxt_st.tx = {1'b0, i_mem_rdata[15:0]};
                    end else begin
                        nxt_st.tx = {1'b0, 8'h00, i_mem_rdata[7:0]};
                    end
                end
            end
            dcd_pkg::S_RESHI: begin
                if (done) begin
                    nxt_st.tx  = {1'b0, st_ff.res_lo};
                    nxt_st.fsm = dcd_pkg::S_IDLE;
                end
            end
            default: begin
                nxt_st.fsm = dcd_pkg::S_IDLE;
            end
        endcase

        // Start of the access once the last word is in
        if (launch) begin
            if (is_mem(st_ff.opc)) begin
                nxt_st.mem_req  = 1'b1;
                nxt_st.mem_addr = align(st_ff.ext_idx < dcd_pkg::EXT_ADDR
                                        ? {st_ff.addr[15:0], rx} : st_ff.addr, sz);
                nxt_st.fsm      = dcd_pkg::S_BUSY;
            end else if (!i_core_halted) begin
                nxt_st.tx  = dcd_pkg::RSP_BERR;
                nxt_st.fsm = dcd_pkg::S_IDLE;
            end else begin
                nxt_st.reg_req = 1'b1;
                nxt_st.fsm     = dcd_pkg::S_BUSY;
            end
        end
        nxt_st.dso = nxt_st.sh_out[16];

        // Register bus: write channels taken in either order
        if (i_s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_addr = 8'(i_s_axi_awaddr);
            nxt_st.aw_got  = 1'b1;
        end
        if (i_s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_data = i_s_axi_wdata;
            nxt_st.w_strb = i_s_axi_wstrb;
            nxt_st.w_got  = 1'b1;
        end
        if (st_ff.bvalid && i_s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        do_aw = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
        if (do_aw) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = dcd_pkg::RESP_ERR;
            if (st_ff.aw_addr == dcd_pkg::ADDR_CTRL) begin
                nxt_st.bresp = dcd_pkg::RESP_OK;
                if (st_ff.w_strb[0]) begin
                    nxt_st.en = st_ff.w_data[0];
                end
            end
        end
        nxt_st.awready = ~nxt_st.aw_got & ~nxt_st.bvalid;
        nxt_st.wready  = ~nxt_st.w_got & ~nxt_st.bvalid;

        // Read channel: one read in flight, unmapped reads zero with error
        do_ar = i_s_axi_arvalid && st_ff.arready;
        if (st_ff.rvalid && i_s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (do_ar) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = dcd_pkg::RESP_OK;
            unique case (8'(i_s_axi_araddr))
                dcd_pkg::ADDR_CTRL: nxt_st.rdata = {31'h00000000, st_ff.en};
                dcd_pkg::ADDR_STAT: nxt_st.rdata = {24'h000000, st_ff.fsm,
                                                    st_ff.last_ill, i_core_halted,
                                                    st_ff.fsm != dcd_pkg::S_IDLE};
                dcd_pkg::ADDR_LAST: nxt_st.rdata = {16'h0000, st_ff.opc};
                default: begin
                    nxt_st.rdata = 32'h00000000;
                    nxt_st.rresp = dcd_pkg::RESP_ERR;
                end
            endcase
        end
        nxt_st.arready = ~nxt_st.rvalid;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_ff        <= '0;
            st_ff.fsm    <= dcd_pkg::S_IDLE;
            st_ff.en     <= dcd_pkg::EN_RST;
            st_ff.tx     <= dcd_pkg::RSP_OK;
            st_ff.sh_out <= dcd_pkg::RSP_OK;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************************
    // Outputs, all from flip-flops
    // ************************************************************
    assign o_dso           = st_ff.dso;
    assign o_reg_req       = st_ff.reg_req;
    assign o_reg_wr        = ~st_ff.opc[dcd_pkg::RW_BIT];
    assign o_reg_class     = st_ff.opc[dcd_pkg::AD_BIT];
    assign o_reg_num       = st_ff.opc[dcd_pkg::RN_HI:0];
    assign o_reg_wdata     = st_ff.data;
    assign o_mem_req       = st_ff.mem_req;
    assign o_mem_wr        = ~st_ff.opc[dcd_pkg::RW_BIT];
    assign o_mem_size      = st_ff.opc[dcd_pkg::SZ_HI:dcd_pkg::SZ_LO];
    assign o_mem_addr      = st_ff.mem_addr;
    assign o_mem_wdata     = st_ff.data;
    assign o_s_axi_awready = st_ff.awready;
    assign o_s_axi_wready  = st_ff.wready;
    assign o_s_axi_bresp   = st_ff.bresp;
    assign o_s_axi_bvalid  = st_ff.bvalid;
    assign o_s_axi_arready = st_ff.arready;
    assign o_s_axi_rdata   = st_ff.rdata;
    assign o_s_axi_rresp   = st_ff.rresp;
    assign o_s_axi_rvalid  = st_ff.rvalid;
endmodule
`default_nettype wire

// ---- dcd_debug_command_decoder_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ************************************
// Port checker for the command decoder
// ************************************
module dcd_port_checker (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_core_halted,
    input  wire logic        o_reg_req,
    input  wire logic        i_reg_done,
    input  wire logic        o_mem_req,
    input  wire logic [1:0]  o_mem_size,
    input  wire logic [31:0] o_mem_addr,
    input  wire logic        i_mem_done,
    input  wire logic        i_s_axi_arvalid,
    input  wire logic        o_s_axi_arready,
    input  wire logic        o_s_axi_rvalid,
    input  wire logic        o_s_axi_bvalid,
    input  wire logic        o_s_axi_awready
);
    // One domain, so one clock and one disable for all
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    a_reg_halted: assert property ($rose(o_reg_req) |-> i_core_halted)
        else $error("register access started while core runs");
    a_reg_hold: assert property (o_reg_req && !i_reg_done |=> o_reg_req)
        else $error("register request dropped early");
    a_reg_drop: assert property (o_reg_req && i_reg_done |=> !o_reg_req)
        else $error("register request outlived completion");
    a_mem_hold: assert property (o_mem_req && !i_mem_done |=> o_mem_req && $stable(o_mem_addr))
        else $error("memory request not held steady");
    a_word_align: assert property (o_mem_req && o_mem_size == 2'h1 |-> !o_mem_addr[0])
        else $error("word address odd");
    a_long_align: assert property (o_mem_req && o_mem_size == 2'h2 |-> o_mem_addr[1:0] == 2'h0)
        else $error("longword address unaligned");
    a_size_legal: assert property (o_mem_req |-> o_mem_size != 2'h3)
        else $error("reserved size reached the bus");
    a_one_access: assert property (!(o_reg_req && o_mem_req))
        else $error("register and memory access together");
    a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("read answer late");
    a_write_block: assert property (o_s_axi_bvalid |-> !o_s_axi_awready)
        else $error("address taken before write response");
endmodule
bind dcd_debug_command_decoder dcd_port_checker dcd_port_checker_inst (.*);
`default_nettype wire

// ---- dcd_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ***************************
// Development host, bit level
// ***************************
module dcd_host_model (
    input  wire logic i_dso,
    output var  logic o_dsclk,
    output var  logic o_dsi
);
    // Shift clock parked low between frames
    initial o_dsclk = 1'b0;
    initial o_dsi = 1'b0;
    // One exchange, control bit first, reply sampled before each rise
    task automatic xfer(input logic [15:0] w, output logic [16:0] r);
        logic [16:0] tx;
        tx = {1'b0, w};
        for (int i = 16; i >= 0; i--) begin
            o_dsi = tx[i];
            #100 r[i] = i_dso;
            o_dsclk = 1'b1;
            #100 o_dsclk = 1'b0;
        end
        o_dsi = ~tx[0]; // Released line shows no stale value
        #900;
    endtask
endmodule
`default_nettype wire

// ---- dcd_debug_command_decoder_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module dcd_debug_command_decoder_test;
    logic        i_core_clk = 1'b0, i_rst = 1'b1, i_core_halted = 1'b1, i_reg_done = 1'b0, i_mem_done = 1'b0;
    logic        i_mem_err = 1'b0, i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
    logic        i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0, i_dsclk, i_dsi, o_dso, o_reg_req, o_reg_wr;
    logic        o_reg_class, o_mem_req, o_mem_wr, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
    logic        o_s_axi_arready, o_s_axi_rvalid;
    logic [1:0]  o_mem_size, o_s_axi_bresp, o_s_axi_rresp;
    logic [2:0]  o_reg_num;
    logic [3:0]  i_s_axi_wstrb = 4'hf;
    logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
    logic [31:0] i_s_axi_wdata = 32'h0, i_reg_rdata = 32'hcafe1234, i_mem_rdata = 32'h0;
    logic [31:0] o_reg_wdata, o_mem_addr, o_mem_wdata, o_s_axi_rdata;
    logic [36:0] reg_cap = '0;
    logic [66:0] mem_cap = '0;
    int          dly = 2, cnt = 0, errors = 0, check_count = 0;

    dcd_debug_command_decoder dcd_debug_command_decoder_inst (.*);
    dcd_host_model host_inst (.i_dso(o_dso), .o_dsclk(i_dsclk), .o_dsi(i_dsi));

    always #12.5 i_core_clk = ~i_core_clk;
    // Core side: finish each access after dly cycles, keep what was asked
    always @(posedge i_core_clk) begin
        cnt <= (o_reg_req || o_mem_req) && !i_reg_done ? cnt + 1 : 0;
        i_reg_done <= (o_reg_req || o_mem_req) && !i_reg_done && cnt == dly;
        i_mem_done <= (o_reg_req || o_mem_req) && !i_reg_done && cnt == dly;
        if (o_reg_req) reg_cap <= {o_reg_wr, o_reg_class, o_reg_num, o_reg_wdata};
        if (o_mem_req) mem_cap <= {o_mem_wr, o_mem_size, o_mem_addr, o_mem_wdata};
    end
    // ***********************
    // Bus and exchange helpers
    // ***********************
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge i_core_clk);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid <= 1'b1;
        i_s_axi_bready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(posedge i_core_clk);
            if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
            if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
            if (o_s_axi_bvalid) begin
                i_s_axi_bready <= 1'b0;
                `CHK(o_s_axi_bresp, er)
                return;
            end
        end
        `CHK(1'b0, 1'b1)
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge i_core_clk);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(posedge i_core_clk);
            if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
            if (o_s_axi_rvalid) begin
                i_s_axi_rready <= 1'b0;
                `CHK({o_s_axi_rresp, o_s_axi_rdata}, {er, d})
                return;
            end
        end
        `CHK(1'b0, 1'b1)
    endtask
    task automatic x(input logic [15:0] w, input logic [16:0] e);
        logic [16:0] r;
        host_inst.xfer(w, r);
        `CHK(r, e)
    endtask
    // *********
    // Scenarios
    // *********
    task automatic t_bus;
        axi_rd(8'h00, 32'h1, 2'h0);
        axi_rd(8'h04, 32'ha, 2'h0);
        axi_rd(8'h0c, 32'h0, 2'h2);
        axi_wr(8'h04, 32'h0, 2'h2);
        axi_wr(8'h00, 32'h1, 2'h0);
    endtask
    task automatic t_regs;
        x(16'h208b, 17'h0ffff);
        x(16'hdead, 17'h10000);
        x(16'hbeef, 17'h10000);
        x(16'h0000, 17'h0ffff);
        `CHK(reg_cap, {1'b1, 1'b1, 3'h3, 32'hdeadbeef})
        x(16'h2185, 17'h0ffff);
        x(16'h0000, {1'b0, i_reg_rdata[31:16]});
        x(16'h0000, {1'b0, i_reg_rdata[15:0]});
        `CHK(reg_cap[36:32], 5'h05)
        @(posedge i_core_clk) i_core_halted <= 1'b0;
        x(16'h2185, 17'h0ffff);
        x(16'h0000, 17'h10001);
        x(16'h2080, 17'h0ffff);
        x(16'h1111, 17'h10000);
        x(16'h2222, 17'h10000);
        x(16'h0000, 17'h10001);
        @(posedge i_core_clk) i_core_halted <= 1'b1;
    endtask
    task automatic t_illegal;
        logic [15:0] bad [5] = '{16'h0200, 16'h1930, 16'h19c0, 16'h0c00, 16'h2980};
        foreach (bad[i]) begin
            x(bad[i], 17'h0ffff);
            axi_rd(8'h04, 32'he, 2'h0);
            axi_rd(8'h08, {16'h0, bad[i]}, 2'h0);
            x(16'h0000, 17'h1ffff);
        end
    endtask
    task automatic t_mem;
        logic [16:0] r;
        @(posedge i_core_clk);
        dly <= 300; // Slow access so an exchange lands inside it
        i_mem_rdata <= 32'h0000a5c3;
        x(16'h1940, 17'h0ffff);
        x(16'h1234, 17'h10000);
        x(16'h5677, 17'h10000);
        x(16'h0000, 17'h10000);
        `CHK(mem_cap[66:32], {1'b0, dcd_pkg::SZ_WORD, 32'h12345676})
        for (int n = 0; n < 400 && o_mem_req; n++) @(posedge i_core_clk);
        x(16'h0000, 17'h0a5c3);
        @(posedge i_core_clk);
        dly <= 2;
        i_mem_err <= 1'b1;
        x(16'h1880, 17'h0ffff);
        x(16'h8000, 17'h10000);
        x(16'h0013, 17'h10000);
        x(16'h1122, 17'h10000);
        x(16'h3344, 17'h10000);
        x(16'h0000, 17'h10001);
        `CHK(mem_cap, {1'b1, dcd_pkg::SZ_LONG, 32'h80000010, 32'h11223344})
        @(posedge i_core_clk);
        i_mem_err <= 1'b0;
        i_mem_rdata <= 32'h89abcdef;
        x(16'h1980, 17'h0ffff);
        x(16'h0000, 17'h10000);
        x(16'h0102, 17'h10000);
        x(16'h0000, 17'h089ab);
        x(16'h0000, 17'h0cdef);
        x(16'h1900, 17'h0ffff);
        x(16'h0000, 17'h10000);
        x(16'h0007, 17'h10000);
        host_inst.xfer(16'h0000, r);
        `CHK({r[16], r[7:0]}, 9'h0ef)
        `CHK(mem_cap[66:32], {1'b0, dcd_pkg::SZ_BYTE, 32'h00000007})
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Guard: the exchanges need about 200 us, allow twice that
    initial begin
        #400000;
        errors++;
        $display("ERROR %0t watchdog expired", $time);
        report_and_stop();
    end
    // Main sequence after an 8-cycle reset
    initial begin
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        t_bus();
        t_regs();
        t_illegal();
        t_mem();
        report_and_stop();
    end
endmodule
`default_nettype wire
